//--- common/fbc_defs.vh
// constants for the flash bypass and sector-check host controller
`ifndef FBC_DEFS_VH
`define FBC_DEFS_VH
// ----------------------------------------------------------------------------
// flash side
// ----------------------------------------------------------------------------
`define FBC_AW          25
`define FBC_SECT_LSB    16
`define FBC_A_555       16'h0555
`define FBC_A_2AA       16'h02AA
`define FBC_D_UNLK1     8'hAA
`define FBC_D_UNLK2     8'h55
`define FBC_D_BYP_ENTRY 8'h20
`define FBC_D_BYP_PROG  8'hA0
`define FBC_D_BYP_EXIT1 8'h90
`define FBC_D_BYP_EXIT2 8'h00
`define FBC_D_ERASE_CHK 8'h35
`define FBC_D_BLANK_CHK 8'h33
`define FBC_D_RESET     8'hF0
`define FBC_DQ_FAIL     5
`define FBC_DQ_TOGGLE   6
// sequence table entry: {last, user data, address select, data byte}
`define FBC_AS_555      2'h0
`define FBC_AS_2AA      2'h1
`define FBC_AS_USER     2'h2
`define FBC_AS_SECT     2'h3
// first table entry of each command
`define FBC_IX_ENTRY    4'h0
`define FBC_IX_PROG     4'h3
`define FBC_IX_EXIT     4'h5
`define FBC_IX_ERASECHK 4'h7
`define FBC_IX_BLANK    4'h8
`define FBC_IX_ABORT    4'h9
`define FBC_IX_SOFT     4'hC
// ----------------------------------------------------------------------------
// software registers (avalon word index)
// ----------------------------------------------------------------------------
`define FBC_REG_CTRL    3'h0
`define FBC_REG_ADDR    3'h1
`define FBC_REG_WDATA   3'h2
`define FBC_REG_STATUS  3'h3
`define FBC_REG_RDATA   3'h4
`define FBC_CTRL_GO     0
`define FBC_CTRL_CMD    1
`define FBC_CTRL_ACCEL  4
`define FBC_CTRL_UNLK   5
`define FBC_CTRL_SUSP   6
`define FBC_CTRL_CLRNE  7
`define FBC_CMD_ENTRY    3'h0
`define FBC_CMD_PROG     3'h1
`define FBC_CMD_EXIT     3'h2
`define FBC_CMD_ERASECHK 3'h3
`define FBC_CMD_BLANK    3'h4
`define FBC_CMD_ABORT    3'h5
`define FBC_CMD_SOFT     3'h6
// ----------------------------------------------------------------------------
// timing at 125 MHz, least times rounded up
// ----------------------------------------------------------------------------
`define FBC_CLK_MHZ     125
`define FBC_T_SU_NS     10
`define FBC_T_WP_NS     35
`define FBC_T_WPH_NS    20
`define FBC_T_ACC_NS    110
`define FBC_T_RGAP_NS   20
`define FBC_CYC(ns)     (((ns) * `FBC_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/fbc_seq_rom.v
// command sequence table with registered read data
`default_nettype none
module fbc_seq_rom (
  input  wire        CLK,
  input  wire        NRST,
  input  wire [3:0]  ADDR,
  output reg  [11:0] DATA
);
`include "fbc_defs.vh"
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DATA <= 12'h000;
    end else begin
      case (ADDR)
        4'h0:    DATA <= {2'b00, `FBC_AS_555, `FBC_D_UNLK1};
        4'h1:    DATA <= {2'b00, `FBC_AS_2AA, `FBC_D_UNLK2};
        4'h2:    DATA <= {2'b10, `FBC_AS_555, `FBC_D_BYP_ENTRY};
        4'h3:    DATA <= {2'b00, `FBC_AS_555, `FBC_D_BYP_PROG};
        4'h4:    DATA <= {2'b11, `FBC_AS_USER, 8'h00};
        4'h5:    DATA <= {2'b00, `FBC_AS_555, `FBC_D_BYP_EXIT1};
        4'h6:    DATA <= {2'b10, `FBC_AS_555, `FBC_D_BYP_EXIT2};
        4'h7:    DATA <= {2'b10, `FBC_AS_SECT, `FBC_D_ERASE_CHK};
        4'h8:    DATA <= {2'b10, `FBC_AS_SECT, `FBC_D_BLANK_CHK};
        4'h9:    DATA <= {2'b00, `FBC_AS_555, `FBC_D_UNLK1};
        4'hA:    DATA <= {2'b00, `FBC_AS_2AA, `FBC_D_UNLK2};
        4'hB:    DATA <= {2'b10, `FBC_AS_555, `FBC_D_RESET};
        4'hC:    DATA <= {2'b10, `FBC_AS_555, `FBC_D_RESET};
        default: DATA <= {2'b10, `FBC_AS_555, `FBC_D_RESET};
      endcase
    end
  end
endmodule // fbc_seq_rom
`default_nettype wire

//--- rtl/fbc_ctrl.v
// host controller for flash bypass programming and sector checks
//
// Operation
// R1: high voltage on accelerate pin enters bypass
// R2: dropping high voltage returns to normal
// R3: buffer abort uses full three-cycle reset
// R4: sectors unlocked before accelerate voltage
// R5: bypass entry AA/555, 55/2AA, 20/555
// R6: bypass program A0 then data
// R7: bypass buffer write skips unlock cycles
// R8: only listed commands valid in bypass
// R9: device ignores other commands in bypass
// R10: bypass exit 90 then 00
// R11: erase status check 35h at sector 555h
// R12: no erase check while busy or suspended
// R13: erase check blocks reads, toggle polling
// R14: erase check bit5 result, busy until clear
// R15: erase check completion through ready bit (code ends the poll when the DQ6 toggle bit stops toggling)
// R16: passing erase check returns controller idle
// R17: untrustworthy sector must be erased again
// R18: blank check 33h at sector 555h
// R19: no blank check while busy or suspended
// R20: blank check reads return polling status
// R21: blank check polls like embedded erase
// R22: blank check bit5 result, busy until clear
// R23: blank check stops at first unerased bit
// R24: blank check end returns controller idle
`default_nettype none
`include "fbc_defs.vh"
module fbc_ctrl #(
  parameter [15:0] POLL_MAX = 16'hFFFF
) (
  input  wire                CLK,
  input  wire                NRST,
  input  wire [2:0]          AVS_ADDRESS,
  input  wire                AVS_READ,
  input  wire                AVS_WRITE,
  input  wire [31:0]         AVS_WRITEDATA,
  output reg  [31:0]         AVS_READDATA,
  output reg                 AVS_WAITREQUEST,
  output reg  [`FBC_AW-1:0]  FL_ADDR,
  input  wire [15:0]         FL_DQ_I,
  output reg  [15:0]         FL_DQ_O,
  output reg                 FL_DQ_OE,
  output reg                 FL_CE_N,
  output reg                 FL_OE_N,
  output reg                 FL_WE_N,
  output reg                 FL_RESET_N,
  output reg                 FL_ACCEL_HV,
  input  wire                FL_RYBY
);
  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam integer C_SU  = `FBC_CYC(`FBC_T_SU_NS);
  localparam integer C_WP  = `FBC_CYC(`FBC_T_WP_NS);
  localparam integer C_WPH = `FBC_CYC(`FBC_T_WPH_NS);
  localparam integer C_ACC = `FBC_CYC(`FBC_T_ACC_NS);
  localparam integer C_RG  = `FBC_CYC(`FBC_T_RGAP_NS);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ROM  = 4'h1;
  localparam [3:0] S_SET  = 4'h2;
  localparam [3:0] S_SU   = 4'h3;
  localparam [3:0] S_WP   = 4'h4;
  localparam [3:0] S_WH   = 4'h5;
  localparam [3:0] S_RST  = 4'h6;
  localparam [3:0] S_RD   = 4'h7;
  localparam [3:0] S_RG   = 4'h8;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [3:0]         state_q;
  reg  [3:0]         step_q;
  reg  [4:0]         cnt_q;
  reg  [2:0]         cmd_q;
  reg  [`FBC_AW-1:0] addr_q;
  reg  [15:0]        wdata_q;
  reg  [15:0]        last_rd_q;
  reg  [15:0]        polls_q;
  reg                have_prev_q;
  reg                done_q;
  reg                busy_q;
  reg                bypass_q;
  reg                unlk_q;
  reg                susp_q;
  reg                fail_q;
  reg                need_erase_q;
  reg                refused_q;
  wire [11:0]        rom_data;
  reg  [3:0]         start_ix;
  reg                cmd_ok;
  reg  [`FBC_AW-1:0] seq_addr;
  reg  [31:0]        rd_mux;

  wire               bus_req = AVS_READ | AVS_WRITE;
  wire               commit_wr = AVS_WRITE & ~AVS_WAITREQUEST;
  wire               ctrl_wr = commit_wr & (AVS_ADDRESS == `FBC_REG_CTRL);
  wire [2:0]         new_cmd = AVS_WRITEDATA[`FBC_CTRL_CMD+2:`FBC_CTRL_CMD];
  wire               is_check = (cmd_q == `FBC_CMD_ERASECHK) ||
                                (cmd_q == `FBC_CMD_BLANK);
  wire [`FBC_AW-1:0] sect_addr = {addr_q[`FBC_AW-1:`FBC_SECT_LSB], `FBC_A_555};
  wire               cnt_end = (cnt_q == 5'h00);
  wire               tog_same = FL_DQ_I[`FBC_DQ_TOGGLE] == last_rd_q[`FBC_DQ_TOGGLE];
  wire               fail_seen = FL_DQ_I[`FBC_DQ_FAIL] & last_rd_q[`FBC_DQ_FAIL];

  fbc_seq_rom u_rom (
    .CLK  (CLK),
    .NRST (NRST),
    .ADDR (step_q),
    .DATA (rom_data)
  );

  // --------------------------------------------------------------------------
  // command admission
  // --------------------------------------------------------------------------
  always @* begin
    start_ix = `FBC_IX_SOFT;
    cmd_ok   = 1'b0;
    case (new_cmd)
      `FBC_CMD_ENTRY: begin
        start_ix = `FBC_IX_ENTRY;
        cmd_ok   = ~bypass_q;
      end
      `FBC_CMD_PROG: begin
        start_ix = `FBC_IX_PROG;
        cmd_ok   = bypass_q; // R8
      end
      `FBC_CMD_EXIT: begin
        start_ix = `FBC_IX_EXIT;
        cmd_ok   = bypass_q; // R8
      end
      `FBC_CMD_ERASECHK: begin
        start_ix = `FBC_IX_ERASECHK;
        cmd_ok   = ~bypass_q & ~AVS_WRITEDATA[`FBC_CTRL_SUSP] & FL_RYBY & ~fail_q; // R12 R8
      end
      `FBC_CMD_BLANK: begin
        start_ix = `FBC_IX_BLANK;
        cmd_ok   = ~bypass_q & ~AVS_WRITEDATA[`FBC_CTRL_SUSP] & FL_RYBY & ~fail_q; // R19 R8
      end
      `FBC_CMD_ABORT: begin
        start_ix = `FBC_IX_ABORT; // R3
        cmd_ok   = 1'b1;
      end
      `FBC_CMD_SOFT: begin
        start_ix = `FBC_IX_SOFT;
        cmd_ok   = 1'b1;
      end
      default: begin
        start_ix = `FBC_IX_SOFT;
        cmd_ok   = 1'b0;
      end
    endcase
  end

  // address of the current sequence cycle
  always @* begin
    case (rom_data[9:8])
      `FBC_AS_555:  seq_addr = {{(`FBC_AW-16){1'b0}}, `FBC_A_555};
      `FBC_AS_2AA:  seq_addr = {{(`FBC_AW-16){1'b0}}, `FBC_A_2AA};
      `FBC_AS_USER: seq_addr = addr_q;
      default:      seq_addr = sect_addr; // R11 R18
    endcase
  end

  // --------------------------------------------------------------------------
  // register read mux
  // --------------------------------------------------------------------------
  always @* begin
    case (AVS_ADDRESS)
      `FBC_REG_CTRL:   rd_mux = {25'h000_0000, susp_q, unlk_q, FL_ACCEL_HV,
                                 cmd_q, 1'b0};
      `FBC_REG_ADDR:   rd_mux = {{(32-`FBC_AW){1'b0}}, addr_q};
      `FBC_REG_WDATA:  rd_mux = {16'h0000, wdata_q};
      `FBC_REG_STATUS: rd_mux = {25'h000_0000, FL_RYBY, refused_q, need_erase_q,
                                 fail_q, FL_ACCEL_HV, bypass_q, busy_q};
      `FBC_REG_RDATA:  rd_mux = {16'h0000, last_rd_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // avalon slave: one wait cycle, access takes effect when waitrequest is low
  // --------------------------------------------------------------------------
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      if (bus_req && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA    <= rd_mux;
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers and sequencer
  // --------------------------------------------------------------------------
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q      <= S_IDLE;
      step_q       <= 4'h0;
      cnt_q        <= 5'h00;
      cmd_q        <= 3'h0;
      addr_q       <= {`FBC_AW{1'b0}};
      wdata_q      <= 16'h0000;
      last_rd_q    <= 16'h0000;
      polls_q      <= 16'h0000;
      have_prev_q  <= 1'b0;
      done_q       <= 1'b0;
      busy_q       <= 1'b0;
      bypass_q     <= 1'b0;
      unlk_q       <= 1'b0;
      susp_q       <= 1'b0;
      fail_q       <= 1'b0;
      need_erase_q <= 1'b0;
      refused_q    <= 1'b0;
      FL_ADDR      <= {`FBC_AW{1'b0}};
      FL_DQ_O      <= 16'h0000;
      FL_DQ_OE     <= 1'b0;
      FL_CE_N      <= 1'b1;
      FL_OE_N      <= 1'b1;
      FL_WE_N      <= 1'b1;
      FL_RESET_N   <= 1'b0;
      FL_ACCEL_HV  <= 1'b0;
    end else begin
      FL_RESET_N <= 1'b1;
      if (commit_wr && AVS_ADDRESS == `FBC_REG_ADDR)
        addr_q <= AVS_WRITEDATA[`FBC_AW-1:0];
      if (commit_wr && AVS_WRITEDATA[`FBC_CTRL_CLRNE] && ctrl_wr)
        need_erase_q <= 1'b0;
      if (commit_wr && AVS_ADDRESS == `FBC_REG_WDATA)
        wdata_q <= AVS_WRITEDATA[15:0];
      // accelerate and mode bits only change while no sequence runs
      if (ctrl_wr && !busy_q) begin
        unlk_q <= AVS_WRITEDATA[`FBC_CTRL_UNLK];
        susp_q <= AVS_WRITEDATA[`FBC_CTRL_SUSP];
        if (AVS_WRITEDATA[`FBC_CTRL_ACCEL] && !FL_ACCEL_HV) begin
          if (AVS_WRITEDATA[`FBC_CTRL_UNLK]) begin // R4
            FL_ACCEL_HV <= 1'b1;
            bypass_q    <= 1'b1; // R1
          end else begin
            refused_q <= 1'b1;
          end
        end else if (!AVS_WRITEDATA[`FBC_CTRL_ACCEL] && FL_ACCEL_HV) begin
          FL_ACCEL_HV <= 1'b0;
          bypass_q    <= 1'b0; // R2
        end
      end
      if (ctrl_wr && AVS_WRITEDATA[`FBC_CTRL_GO]) begin
        if (!busy_q && cmd_ok) begin
          busy_q    <= 1'b1;
          refused_q <= 1'b0;
          cmd_q     <= new_cmd;
          step_q    <= start_ix;
          state_q   <= S_ROM;
        end else begin
          refused_q <= 1'b1;
        end
      end
      case (state_q)
        S_IDLE: begin
          cnt_q <= 5'h00;
        end
        S_ROM: begin
          state_q <= S_SET;
        end
        S_SET: begin
          FL_ADDR  <= seq_addr; // R5 R6 R10
          FL_DQ_O  <= rom_data[10] ? wdata_q : {8'h00, rom_data[7:0]};
          FL_DQ_OE <= 1'b1;
          FL_CE_N  <= 1'b0;
          cnt_q    <= C_SU[4:0] - 5'h01;
          state_q  <= S_SU;
        end
        S_SU: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            FL_WE_N <= 1'b0;
            cnt_q   <= C_WP[4:0] - 5'h01;
            state_q <= S_WP;
          end
        end
        S_WP: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            FL_WE_N <= 1'b1;
            cnt_q   <= C_WPH[4:0] - 5'h01;
            state_q <= S_WH;
          end
        end
        S_WH: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            FL_CE_N  <= 1'b1;
            FL_DQ_OE <= 1'b0;
            if (!rom_data[11]) begin
              step_q  <= step_q + 4'h1;
              state_q <= S_ROM;
            end else if (is_check) begin
              // sector check launched: poll the toggle bit until it settles
              have_prev_q <= 1'b0;
              done_q      <= 1'b0;
              polls_q     <= 16'h0000;
              state_q     <= S_RST; // R13 R20
            end else begin
              if (cmd_q == `FBC_CMD_ENTRY)
                bypass_q <= 1'b1;
              if (cmd_q == `FBC_CMD_EXIT)
                bypass_q <= 1'b0; // R10
              if (cmd_q == `FBC_CMD_SOFT)
                fail_q <= 1'b0;
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        S_RST: begin
          FL_ADDR <= sect_addr;
          FL_CE_N <= 1'b0;
          FL_OE_N <= 1'b0;
          cnt_q   <= C_ACC[4:0] - 5'h01;
          state_q <= S_RD;
        end
        S_RD: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            FL_CE_N     <= 1'b1;
            FL_OE_N     <= 1'b1;
            last_rd_q   <= FL_DQ_I;
            have_prev_q <= 1'b1;
            polls_q     <= polls_q + 16'h0001;
            cnt_q       <= C_RG[4:0] - 5'h01;
            state_q     <= S_RG;
            if (have_prev_q && tog_same) begin
              done_q <= 1'b1; // R15 R21
              fail_q <= 1'b0;
            end else if (have_prev_q && fail_seen) begin
              done_q       <= 1'b1; // R14 R22 R23
              fail_q       <= 1'b1;
              need_erase_q <= 1'b1; // R17
            end else if (polls_q == POLL_MAX - 16'h0001) begin
              // a stuck device must not hang the host forever
              done_q       <= 1'b1;
              fail_q       <= 1'b1;
              need_erase_q <= 1'b1;
            end
          end
        end
        S_RG: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            if (done_q) begin
              busy_q  <= 1'b0; // R16 R24
              state_q <= S_IDLE;
            end else begin
              state_q <= S_RST;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fbc_ctrl
`default_nettype wire

//--- dv/fbc_ctrl_monitor.sv
// assertions on the host controller's bus and flash pins
`default_nettype none
`include "fbc_defs.vh"
module fbc_ctrl_monitor (
  input wire logic               CLK,
  input wire logic               NRST,
  input wire logic [2:0]         AVS_ADDRESS,
  input wire logic               AVS_WRITE,
  input wire logic [31:0]        AVS_WRITEDATA,
  input wire logic               AVS_WAITREQUEST,
  input wire logic [`FBC_AW-1:0] FL_ADDR,
  input wire logic [15:0]        FL_DQ_O,
  input wire logic               FL_DQ_OE,
  input wire logic               FL_CE_N,
  input wire logic               FL_OE_N,
  input wire logic               FL_WE_N,
  input wire logic               FL_ACCEL_HV,
  input wire logic               FL_RYBY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ---------------------------------------------------------------------------
  // helper state: last two written bytes, software flags
  // ---------------------------------------------------------------------------
  logic [7:0] p1_q, p2_q;
  logic       unlk_q, susp_q;
  wire        chk_byte = (FL_DQ_O[7:0] == 8'h35 || FL_DQ_O[7:0] == 8'h33);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      unlk_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      if ($fell(FL_WE_N)) begin
        p1_q <= FL_DQ_O[7:0];
        p2_q <= p1_q;
      end
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `FBC_REG_CTRL) begin
        unlk_q <= AVS_WRITEDATA[5];
        susp_q <= AVS_WRITEDATA[6];
      end
    end
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  a_entry_order: assert property ($fell(FL_WE_N) && FL_DQ_O[7:0] == 8'h20 |->
    FL_ADDR[15:0] == 16'h0555 && p1_q == 8'h55 && p2_q == 8'hAA) else $error("bad entry");
  a_we_pulse: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*5] ##1 FL_WE_N)
    else $error("write pulse width wrong");
  a_write_frame: assert property (!FL_WE_N |-> !FL_CE_N && FL_DQ_OE && FL_OE_N
    && $stable(FL_ADDR) && $stable(FL_DQ_O)) else $error("write frame broken");
  a_prog_next: assert property ($rose(FL_WE_N) && FL_DQ_O[7:0] == 8'hA0 |->
    ##[1:20] $fell(FL_WE_N)) else $error("program data write missing");
  a_exit_pair: assert property ($rose(FL_WE_N) && FL_DQ_O[7:0] == 8'h90 |->
    ##[1:20] ($fell(FL_WE_N) && FL_DQ_O == 16'h0000)) else $error("exit pair broken");
  a_check_addr: assert property ($fell(FL_WE_N) && chk_byte |-> FL_ADDR[15:0] == 16'h0555)
    else $error("check command at wrong offset");
  a_check_idle: assert property ($fell(FL_WE_N) && chk_byte |-> FL_RYBY && !susp_q)
    else $error("check issued while busy or suspended");
  a_abort_full: assert property ($fell(FL_WE_N) && FL_DQ_O[7:0] == 8'hF0 && FL_ACCEL_HV
    |-> p1_q == 8'h55 && p2_q == 8'hAA) else $error("short abort reset");
  a_hv_unlocked: assert property ($rose(FL_ACCEL_HV) |-> unlk_q)
    else $error("high voltage before unlock");
  a_read_quiet: assert property (!FL_OE_N |-> FL_WE_N && !FL_DQ_OE && !FL_CE_N)
    else $error("read cycle overlaps a write");
endmodule // fbc_ctrl_monitor
`default_nettype wire

//--- dv/fbc_flash_model.sv
// behavioural flash device: bypass commands and sector checks
`default_nettype none
`include "fbc_defs.vh"
module fbc_flash_model (
  input  wire logic [`FBC_AW-1:0] addr,
  input  wire logic [15:0]        dq_w,
  input  wire logic               ce_n,
  input  wire logic               oe_n,
  input  wire logic               we_n,
  input  wire logic               rst_n,
  input  wire logic               hv,
  input  wire logic               nonblank,
  output logic [15:0]             dq_r,
  output logic                    ryby,
  output logic                    byp,
  output logic [`FBC_AW-1:0]      pa_q,
  output logic [15:0]             pd_q,
  output logic [`FBC_AW-1:0]      ca_q,
  output logic [3:0]              aborts_q
);
  logic [1:0]  ul_q;
  logic        byp_q, pset_q, x90_q, busy_q, fail_q, tog_q, blank_q;
  logic [3:0]  rd_q;
  logic [15:0] last_q;
  wire  [15:0] a = addr[15:0];
  wire  [7:0]  d = dq_w[7:0];
  assign byp  = byp_q | hv;
  assign ryby = !busy_q;
  // released bus shows a changing pattern, not a held value
  assign dq_r = (!oe_n && !ce_n) ? (busy_q ? {9'h000, tog_q, fail_q, 5'h00} : 16'hFFFF)
                                 : ~last_q;
  // ---------------------------------------------------------------------------
  // reads poll, writes decode
  // ---------------------------------------------------------------------------
  always @(negedge oe_n or posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      {ul_q, byp_q, pset_q, x90_q, busy_q, fail_q, tog_q, blank_q, rd_q} <= '0;
      {pa_q, pd_q, ca_q, aborts_q, last_q} <= '0;
    end else if (!oe_n && !ce_n) begin
      last_q <= ~last_q;
      if (busy_q) begin
        rd_q <= rd_q + 4'h1;
        tog_q <= ~tog_q;
        if (nonblank && rd_q == (blank_q ? 4'h0 : 4'h2)) fail_q <= 1'b1;
        else if (!nonblank && rd_q == 4'h3) busy_q <= 1'b0;
      end
    end else if (we_n && !ce_n) begin
      if (busy_q) begin
        if (fail_q && d == 8'hF0) {busy_q, fail_q} <= 2'b00;
      end else if (pset_q) begin
        pa_q <= addr;
        pd_q <= dq_w;
        pset_q <= 1'b0;
      end else if (x90_q) begin
        x90_q <= 1'b0;
        if (d == 8'h00) byp_q <= 1'b0;
      end else if (ul_q == 2'h2) begin
        ul_q <= 2'h0;
        if (d == 8'h20 && a == 16'h0555 && !byp) byp_q <= 1'b1;
        if (d == 8'hF0) aborts_q <= aborts_q + 4'h1;
      end else if (d == 8'hAA && a == 16'h0555 && ul_q == 2'h0) ul_q <= 2'h1;
      else if (d == 8'h55 && a == 16'h02AA && ul_q == 2'h1) ul_q <= 2'h2;
      else if (byp && d == 8'hA0) pset_q <= 1'b1;
      else if (byp && d == 8'h90) x90_q <= 1'b1;
      else if (!byp && a == 16'h0555 && (d == 8'h35 || d == 8'h33)) begin
        {busy_q, rd_q, ca_q} <= {1'b1, 4'h0, addr};
        blank_q <= (d == 8'h33);
      end else ul_q <= 2'h0;
    end
  end
endmodule // fbc_flash_model
`default_nettype wire

//--- dv/fbc_ctrl_tb.sv
// self-checking bench for the flash bypass and sector-check host controller
`default_nettype none
`include "fbc_defs.vh"
module fbc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               CLK, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, nonblank, byp;
  logic [2:0]         AVS_ADDRESS;
  logic [31:0]        AVS_WRITEDATA, AVS_READDATA, st;
  logic [`FBC_AW-1:0] FL_ADDR, pa, ca;
  logic [15:0]        FL_DQ_I, FL_DQ_O, pd;
  logic               FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N, FL_ACCEL_HV, FL_RYBY;
  logic [3:0]         aborts;
  int                 failures, cmp_count;
  // rows: control byte written, then {device bypass, status[5:0]} once idle
  logic [7:0] row_ctl [15] = '{8'h01, 8'h01, 8'h03, 8'h07, 8'h05, 8'h03, 8'h47, 8'h07,
                               8'h10, 8'h09, 8'h30, 8'h3B, 8'h33, 8'h00, 8'h0D};
  logic [6:0] row_exp [15] = '{7'h42, 7'h62, 7'h42, 7'h62, 7'h00, 7'h20, 7'h20, 7'h00,
                               7'h20, 7'h00, 7'h46, 7'h46, 7'h46, 7'h00, 7'h00};
  fbc_ctrl #(.POLL_MAX(16'h0008)) dut_u (.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .FL_ADDR(FL_ADDR),
    .FL_DQ_I(FL_DQ_I), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
    .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_RESET_N(FL_RESET_N),
    .FL_ACCEL_HV(FL_ACCEL_HV), .FL_RYBY(FL_RYBY));
  fbc_flash_model flash_u (.addr(FL_ADDR), .dq_w(FL_DQ_O), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
    .we_n(FL_WE_N), .rst_n(FL_RESET_N), .hv(FL_ACCEL_HV), .nonblank(nonblank),
    .dq_r(FL_DQ_I), .ryby(FL_RYBY), .byp(byp), .pa_q(pa), .pd_q(pd), .ca_q(ca),
    .aborts_q(aborts));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string n, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    st = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  // write control, then poll status until busy drops (bounded)
  task automatic run(input logic [7:0] c);
    int n;
    n = 0;
    bus(1'b1, `FBC_REG_CTRL, {24'h00_0000, c});
    do begin
      bus(1'b0, `FBC_REG_STATUS, 32'h0000_0000);
      n++;
    end while (st[0] !== 1'b0 && n < 500);
    check("busy cleared", st[0], 1'b0);
  endtask
  task automatic give_verdict;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    repeat (40000) @(posedge CLK);
    failures++;
    give_verdict;
  end
  initial begin
    {NRST, AVS_READ, AVS_WRITE, nonblank} = 4'h0;
    AVS_ADDRESS = 3'h0;
    AVS_WRITEDATA = 32'h0000_0000;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    bus(1'b0, `FBC_REG_STATUS, 32'h0000_0000);
    check("status after reset", st, 32'h0000_0040);
    bus(1'b0, 3'h7, 32'h0000_0000);
    check("unmapped read", st, 32'h0000_0000);
    bus(1'b1, `FBC_REG_ADDR, 32'h0002_0123);
    bus(1'b1, `FBC_REG_WDATA, 32'h0000_BEEF);
    for (int i = 0; i < 15; i++) begin
      run(row_ctl[i]);
      check("status row", {byp, st[5:0]}, row_exp[i]);
    end
    check("programmed word", {pa, pd}, {25'h002_0123, 16'hBEEF});
    check("abort resets", aborts, 4'h1);
    check("check address", ca, 25'h002_0555);
    bus(1'b0, `FBC_REG_CTRL, 32'h0000_0000);
    check("control readback", st, 32'h0000_000C);
    bus(1'b0, `FBC_REG_RDATA, 32'h0000_0000);
    check("last polled word", st, 32'h0000_FFFF);
    nonblank <= 1'b1;
    run(8'h09);
    check("blank fail", {FL_RYBY, st[5:0]}, 7'h18);
    run(8'h07);
    check("check while failed", st[5:0], 6'h38);
    run(8'h0D);
    check("soft reset clears fail", {FL_RYBY, st[3]}, 2'b10);
    run(8'h80);
    check("need erase cleared", st[4], 1'b0);
    run(8'h07);
    check("erase check fail", {FL_RYBY, st[3]}, 2'b01);
    run(8'h0D);
    check("ready after reset", FL_RYBY, 1'b1);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    check("pins in reset", {FL_RESET_N, FL_CE_N, AVS_WAITREQUEST}, 3'b011);
    NRST <= 1'b1;
    @(posedge CLK);
    bus(1'b0, `FBC_REG_STATUS, 32'h0000_0000);
    check("status after second reset", {FL_RESET_N, st}, 33'h1_0000_0040);
    give_verdict;
  end
endmodule // fbc_ctrl_tb
bind fbc_ctrl fbc_ctrl_monitor mon_u (.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
  .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_ACCEL_HV(FL_ACCEL_HV), .FL_RYBY(FL_RYBY));
`default_nettype wire
